/* inc/sev_pkg.sv */
// Shared constants for the status event register bank
package sev_pkg;
  // Register width
  localparam int REG_W = 16;
  // Bit positions, measurement event register
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_LOW1     = 1;
  localparam int BIT_HIGH1    = 2;
  localparam int BIT_LOW2     = 3;
  localparam int BIT_HIGH2    = 4;
  localparam int BIT_READY    = 5;
  localparam int BIT_HAS_RDG  = 7;
  localparam int BIT_HALF     = 8;
  localparam int BIT_FULL     = 9;
  // Bit positions, questionable event register
  localparam int BIT_JUNCTION = 4;
  localparam int BIT_CAL      = 8;
  localparam int BIT_WARN     = 14;
  // Bit positions, operation event register
  localparam int BIT_MEASURING  = 4;
  localparam int BIT_TRIGGERING = 5;
  localparam int BIT_IDLE       = 10;
  // Bits that exist in each register; all others stay zero
  localparam logic [15:0] MEAS_USED = 16'h03bf;
  localparam logic [15:0] QUES_USED = 16'h4110;
  localparam logic [15:0] OPER_USED = 16'h0430;
  // Reset values
  localparam logic [15:0] EVT_RESET = 16'h0000;
  localparam logic [15:0] ENA_RESET = 16'h0000;
  // Register select, one-hot
  typedef enum logic [2:0] {
    SEV_SEL_MEAS = 3'b001,
    SEV_SEL_QUES = 3'b010,
    SEV_SEL_OPER = 3'b100
  } sev_sel_t;
endpackage

/* inc/sev_evt_if.sv */
`timescale 1ns/1ps
// Signals between the controller and one event register bank
interface sev_evt_if;
  logic        ce;      // Clock enable
  logic [15:0] cond;    // Condition inputs, level
  logic [15:0] used;    // Bits that exist
  logic        rdClr;   // Read of this register, clears it
  logic        enWr;    // Enable register write
  logic        preset;  // Clear enable register
  logic [15:0] enData;  // Enable write data
  logic [15:0] evt;     // Event register contents
  logic [15:0] ena;     // Enable register contents
  logic        summary; // Masked summary
  modport bank (
    input  ce, cond, used, rdClr, enWr, preset, enData,
    output evt, ena, summary
  );
  modport ctrl (
    output ce, cond, used, rdClr, enWr, preset, enData,
    input  evt, ena, summary
  );
endinterface

/* rtl/sev_event_bank.sv */
`timescale 1ns/1ps
// One event register with its enable mask and summary bit
module sev_event_bank
  import sev_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  sev_evt_if.bank  io
);
  // Whole state of the bank
  typedef struct packed {
    logic [15:0] evt;     // Latched events
    logic [15:0] ena;     // Enable mask
    logic        summary; // Any enabled event
  } sev_bank_t;

  sev_bank_t st_r;   // Registered state
  sev_bank_t st_nxt; // Next state

  // Next state; a condition in the cycle of a read wins over the clear
  always_comb begin
    st_nxt = st_r;
    if (io.ce) begin
      // Clear on read, then latch conditions, unused bits forced low
      st_nxt.evt = ((st_r.evt & ~{REG_W{io.rdClr}}) | io.cond)
                   & io.used;
      // Preset beats a write of the enable mask
      if (io.preset) begin
        st_nxt.ena = ENA_RESET;
      end else if (io.enWr) begin
        st_nxt.ena = io.enData;
      end
      // Masked events drive the summary
      st_nxt.summary = |(st_nxt.evt & st_nxt.ena);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '{evt: EVT_RESET, ena: ENA_RESET, summary: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io.evt     = st_r.evt;
  assign io.ena     = st_r.ena;
  assign io.summary = st_r.summary;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Unused positions never read as one
  a_unused_zero: assert property ((io.evt & ~io.used) == 16'h0000)
    else $error("unused event bit set");
  // Summary follows the masked events
  a_summary_mask: assert property (
    io.summary == |(io.evt & io.ena))
    else $error("summary does not match masked events");
endmodule

/* rtl/sev_status_regs.sv */
`timescale 1ns/1ps
// How it works
// - Reading an event register clears it
// - Read returns register bits as a value
// - Bit 0 measurement: reading overflow
// - Bit 1 measurement: below lower limit one
// - Bit 2 measurement: above upper limit one
// - Bit 3 measurement: below lower limit two
// - Bit 4 measurement: above upper limit two
// - Bit 5 measurement: reading processed
// - Bit 7 measurement: buffer holds two readings
// - Bit 8 measurement: buffer half full
// - Bit 9 measurement: buffer full
// - Bit 4 questionable: invalid reference junction
// - Bad calibration sets bit 8, substitutes default
// - Calibration error clears after good calibration
// - Bit 14 questionable: command parameter ignored
// - Fault lamp on while questionable event present
// - Bit 4 operation: measuring
// - Bit 5 operation: in device action
// - Bit 10 operation: idle
// - Enable mask gates event onto summary
module sev_status_regs
  import sev_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic        readingOverflow,
  input  wire logic        belowLowerLimitOne,
  input  wire logic        aboveUpperLimitOne,
  input  wire logic        belowLowerLimitTwo,
  input  wire logic        aboveUpperLimitTwo,
  input  wire logic        newReadingReady,
  input  wire logic        bufferHasReadings,
  input  wire logic        bufferHalfLevel,
  input  wire logic        bufferFullFlag,
  input  wire logic        junctionInvalid,
  input  wire logic        calConstBad,
  input  wire logic        calDone,
  input  wire logic        cmdParamIgnored,
  input  wire logic        measuring,
  input  wire logic        triggering,
  input  wire logic        idle,
  input  wire logic        queryStrobe,
  input  wire sev_sel_t    querySel,
  input  wire logic        enableWrite,
  input  wire sev_sel_t    enableSel,
  input  wire logic [15:0] enableData,
  input  wire logic        presetStrobe,
  output logic             queryValid,
  output logic [15:0]      queryData,
  output logic             measSummary,
  output logic             quesSummary,
  output logic             operSummary,
  output logic             calDefaultUsed,
  output logic             faultLamp
);
  // Pick one of three words by one-hot select; unknown codes give zero
  function automatic logic [15:0] pickWord(
    input sev_sel_t    sel,
    input logic [15:0] m,
    input logic [15:0] q,
    input logic [15:0] o
  );
    logic [15:0] w;
    w = 16'h0000;
    if (sel == SEV_SEL_MEAS) begin
      w = m;
    end else if (sel == SEV_SEL_QUES) begin
      w = q;
    end else if (sel == SEV_SEL_OPER) begin
      w = o;
    end
    return w;
  endfunction

  // Whole state of the controller
  typedef struct packed {
    logic [15:0] queryData;  // Last value read
    logic        queryValid; // Answer pulse
    logic        calErr;     // Calibration constant invalid
    logic        faultLamp;  // Front-panel fault indicator
  } sev_top_t;

  sev_top_t st_r;   // Registered state
  sev_top_t st_nxt; // Next state

  sev_evt_if mIf (); // Measurement bank
  sev_evt_if qIf (); // Questionable bank
  sev_evt_if oIf (); // Operation bank

  logic [15:0] mCond; // Measurement conditions
  logic [15:0] qCond; // Questionable conditions
  logic [15:0] oCond; // Operation conditions
  logic        rdAny; // Accepted query this cycle

  // Gather measurement conditions at their bit positions
  always_comb begin
    mCond = 16'h0000;
    mCond[BIT_OVERFLOW] = readingOverflow;
    mCond[BIT_LOW1]     = belowLowerLimitOne;
    mCond[BIT_HIGH1]    = aboveUpperLimitOne;
    mCond[BIT_LOW2]     = belowLowerLimitTwo;
    mCond[BIT_HIGH2]    = aboveUpperLimitTwo;
    mCond[BIT_READY]    = newReadingReady;
    mCond[BIT_HAS_RDG]  = bufferHasReadings;
    mCond[BIT_HALF]     = bufferHalfLevel;
    mCond[BIT_FULL]     = bufferFullFlag;
  end

  // Questionable conditions; calibration bit stays while the error holds
  always_comb begin
    qCond = 16'h0000;
    qCond[BIT_JUNCTION] = junctionInvalid;
    qCond[BIT_CAL]      = st_r.calErr;
    qCond[BIT_WARN]     = cmdParamIgnored;
  end

  // Operation conditions
  always_comb begin
    oCond = 16'h0000;
    oCond[BIT_MEASURING]  = measuring;
    oCond[BIT_TRIGGERING] = triggering;
    oCond[BIT_IDLE]       = idle;
  end

  assign rdAny = clkEn & queryStrobe;

  // Drive the three banks
  assign mIf.ce     = clkEn;
  assign mIf.cond   = mCond;
  assign mIf.used   = MEAS_USED;
  assign mIf.rdClr  = rdAny & (querySel == SEV_SEL_MEAS);
  assign mIf.enWr   = enableWrite & (enableSel == SEV_SEL_MEAS);
  assign mIf.preset = presetStrobe;
  assign mIf.enData = enableData;

  assign qIf.ce     = clkEn;
  assign qIf.cond   = qCond;
  assign qIf.used   = QUES_USED;
  assign qIf.rdClr  = rdAny & (querySel == SEV_SEL_QUES);
  assign qIf.enWr   = enableWrite & (enableSel == SEV_SEL_QUES);
  assign qIf.preset = presetStrobe;
  assign qIf.enData = enableData;

  assign oIf.ce     = clkEn;
  assign oIf.cond   = oCond;
  assign oIf.used   = OPER_USED;
  assign oIf.rdClr  = rdAny & (querySel == SEV_SEL_OPER);
  assign oIf.enWr   = enableWrite & (enableSel == SEV_SEL_OPER);
  assign oIf.preset = presetStrobe;
  assign oIf.enData = enableData;

  // Measurement event register
  sev_event_bank uMeas (
    .clk   (clk),
    .reset (reset),
    .io    (mIf.bank)
  );

  // Questionable event register
  sev_event_bank uQues (
    .clk   (clk),
    .reset (reset),
    .io    (qIf.bank)
  );

  // Operation event register
  sev_event_bank uOper (
    .clk   (clk),
    .reset (reset),
    .io    (oIf.bank)
  );

  // Next state of the controller
  always_comb begin
    st_nxt = st_r;
    if (clkEn) begin
      // Answer pulse lasts one enabled cycle
      st_nxt.queryValid = 1'b0;
      if (queryStrobe) begin
        // Binary pattern is the decimal weight sum
        st_nxt.queryData  = pickWord(querySel, mIf.evt,
                                     qIf.evt, oIf.evt);
        st_nxt.queryValid = 1'b1;
      end
      // Bad constant found beats a finished calibration
      if (calConstBad) begin
        st_nxt.calErr = 1'b1;
      end else if (calDone) begin
        st_nxt.calErr = 1'b0;
      end
      // Lamp follows the questionable register
      st_nxt.faultLamp = |qIf.evt;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '{queryData: 16'h0000, queryValid: 1'b0,
                calErr: 1'b0, faultLamp: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs, all from flip-flops
  assign queryValid     = st_r.queryValid;
  assign queryData      = st_r.queryData;
  assign measSummary    = mIf.summary;
  assign quesSummary    = qIf.summary;
  assign operSummary    = oIf.summary;
  assign calDefaultUsed = st_r.calErr;
  assign faultLamp      = st_r.faultLamp;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // A measurement query taken this cycle
  sequence s_measRead;
    clkEn && queryStrobe && querySel == SEV_SEL_MEAS;
  endsequence

  // Calibration fault sets the error flag, then the event bit
  sequence s_calFault;
    clkEn && calConstBad;
  endsequence

  // A questionable query taken this cycle
  sequence s_quesRead;
    clkEn && queryStrobe && querySel == SEV_SEL_QUES;
  endsequence

  // An operation query taken this cycle
  sequence s_operRead;
    clkEn && queryStrobe && querySel == SEV_SEL_OPER;
  endsequence

  // A query answers one cycle later with the register value
  a_read_value: assert property (
    clkEn && queryStrobe |=> queryValid &&
    queryData == pickWord($past(querySel), $past(mIf.evt),
                          $past(qIf.evt), $past(oIf.evt)))
    else $error("query answer wrong");
  // After a read only fresh conditions remain
  a_read_clears: assert property (
    s_measRead |=> mIf.evt == ($past(mCond) & MEAS_USED))
    else $error("measurement read did not clear");
  // Overflow sets bit 0
  a_meas_over: assert property (
    clkEn && readingOverflow |=> mIf.evt[BIT_OVERFLOW])
    else $error("overflow not latched");
  // Lower limit one sets bit 1
  a_meas_low1: assert property (
    clkEn && belowLowerLimitOne |=> mIf.evt[BIT_LOW1])
    else $error("low limit one not latched");
  // Upper limit one sets bit 2
  a_meas_high1: assert property (
    clkEn && aboveUpperLimitOne |=> mIf.evt[BIT_HIGH1])
    else $error("high limit one not latched");
  // Lower limit two sets bit 3
  a_meas_low2: assert property (
    clkEn && belowLowerLimitTwo |=> mIf.evt[BIT_LOW2])
    else $error("low limit two not latched");
  // Upper limit two sets bit 4
  a_meas_high2: assert property (
    clkEn && aboveUpperLimitTwo |=> mIf.evt[BIT_HIGH2])
    else $error("high limit two not latched");
  // New reading sets bit 5
  a_meas_ready: assert property (
    clkEn && newReadingReady |=> mIf.evt[BIT_READY])
    else $error("reading ready not latched");
  // Buffer readings set bit 7
  a_buf_has: assert property (
    clkEn && bufferHasReadings |=> mIf.evt[BIT_HAS_RDG])
    else $error("buffer available not latched");
  // Half level sets bit 8
  a_buf_half: assert property (
    clkEn && bufferHalfLevel |=> mIf.evt[BIT_HALF])
    else $error("buffer half not latched");
  // Full buffer sets bit 9
  a_buf_full: assert property (
    clkEn && bufferFullFlag |=> mIf.evt[BIT_FULL])
    else $error("buffer full not latched");
  // Junction fault sets questionable bit 4
  a_ques_junc: assert property (
    clkEn && junctionInvalid |=> qIf.evt[BIT_JUNCTION])
    else $error("junction fault not latched");
  // Bad constant: default in use next cycle, event bit one later
  a_cal_fault: assert property (
    s_calFault |=> calDefaultUsed
                   ##1 (!$past(clkEn) || qIf.evt[BIT_CAL]))
    else $error("calibration fault not flagged");
  // Error leaves only after a good calibration
  a_cal_clear: assert property (
    $fell(calDefaultUsed) |-> $past(calDone) && !$past(calConstBad))
    else $error("calibration error cleared without calibration");
  // Ignored parameter sets questionable bit 14
  a_ques_warn: assert property (
    clkEn && cmdParamIgnored |=> qIf.evt[BIT_WARN])
    else $error("command warning not latched");
  // Lamp mirrors presence of any questionable event
  a_fault_lamp: assert property (
    clkEn |=> faultLamp == |$past(qIf.evt))
    else $error("fault lamp wrong");
  // Measuring sets operation bit 4
  a_oper_meas: assert property (
    clkEn && measuring |=> oIf.evt[BIT_MEASURING])
    else $error("measuring not latched");
  // Device action sets operation bit 5
  a_oper_trig: assert property (
    clkEn && triggering |=> oIf.evt[BIT_TRIGGERING])
    else $error("triggering not latched");
  // Idle sets operation bit 10
  a_oper_idle: assert property (
    clkEn && idle |=> oIf.evt[BIT_IDLE])
    else $error("idle not latched");
  // Preset clears every enable, so no summary can rise
  a_preset_mask: assert property (
    clkEn && presetStrobe |=> !measSummary && !quesSummary
                            && !operSummary)
    else $error("summary set after preset");
  // Unused operation bits never set
  a_oper_unused: assert property (
    (oIf.evt & ~OPER_USED) == 16'h0000)
    else $error("unused operation bit set");
  // Questionable read leaves only fresh conditions
  a_ques_clears: assert property (
    s_quesRead |=> qIf.evt == ($past(qCond) & QUES_USED))
    else $error("questionable read did not clear");
  // Operation read leaves only fresh conditions
  a_oper_clears: assert property (
    s_operRead |=> oIf.evt == ($past(oCond) & OPER_USED))
    else $error("operation read did not clear");
  // Unknown select answers zero
  a_bad_sel: assert property (
    clkEn && queryStrobe && querySel != SEV_SEL_MEAS
    && querySel != SEV_SEL_QUES && querySel != SEV_SEL_OPER
    |=> queryData == 16'h0000)
    else $error("unknown select answer not zero");
  // No query, no answer pulse
  a_valid_pulse: assert property (
    clkEn && !queryStrobe |=> !queryValid)
    else $error("answer pulse without query");
  // Frozen clock enable keeps every register, nothing is cleared
  a_freeze_hold: assert property (
    !clkEn |=> $stable(queryData) && $stable(queryValid)
    && $stable(calDefaultUsed) && $stable(faultLamp)
    && $stable(mIf.evt) && $stable(qIf.evt) && $stable(oIf.evt))
    else $error("state moved while clock enable low");
  // Calibration bit returns after every read while the error holds
  a_cal_hold: assert property (
    clkEn && calDefaultUsed |=> qIf.evt[BIT_CAL])
    else $error("calibration bit lost while error holds");
  // Error stays until a calibration finishes
  a_cal_keeps: assert property (
    calDefaultUsed && !(clkEn && calDone) |=> calDefaultUsed)
    else $error("calibration error left early");
  // Unused measurement bits never set
  a_meas_unused: assert property (
    (mIf.evt & ~MEAS_USED) == 16'h0000)
    else $error("unused measurement bit set");
  // Unused questionable bits never set
  a_ques_unused: assert property (
    (qIf.evt & ~QUES_USED) == 16'h0000)
    else $error("unused questionable bit set");
endmodule

/* sim/sev_host_model.sv */
`timescale 1ns/1ps
// Host side: issues register reads, enable writes and presets
module sev_host_model
  import sev_pkg::*;
(
  input  wire logic        clk,
  output sev_sel_t         querySel,
  output logic             queryStrobe,
  output logic             enableWrite,
  output sev_sel_t         enableSel,
  output logic [15:0]      enableData,
  output logic             presetStrobe,
  input  wire logic        queryValid,
  input  wire logic [15:0] queryData
);
  // Quiet bus at time zero
  initial begin
    querySel     = SEV_SEL_MEAS;
    queryStrobe  = 1'b0;
    enableWrite  = 1'b0;
    enableSel    = SEV_SEL_MEAS;
    enableData   = 16'h0000;
    presetStrobe = 1'b0;
  end
  // One read; caller enters just after an edge, so does the exit
  task automatic query(input logic [2:0] sel, output logic [15:0] data,
                       output logic seen);
    int n;
    n = 0;
    querySel    = sev_sel_t'(sel);
    queryStrobe = 1'b1;
    @(posedge clk);
    #1;
    queryStrobe = 1'b0;
    // Select no longer meaningful, so show a changed pattern
    querySel = sev_sel_t'(~sel);
    while (!queryValid && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    seen = queryValid;
    data = queryData;
    @(posedge clk);
    #1;
  endtask
  // Enable register write, data scrambled once taken
  task automatic write_en(input sev_sel_t sel, input logic [15:0] data);
    enableSel   = sel;
    enableData  = data;
    enableWrite = 1'b1;
    @(posedge clk);
    #1;
    enableWrite = 1'b0;
    enableData  = ~data;
    @(posedge clk);
    #1;
  endtask
  // Clear all enable registers
  task automatic preset();
    presetStrobe = 1'b1;
    @(posedge clk);
    #1;
    presetStrobe = 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
// Compare one value, count it, report a mismatch
`define CHK(act, exp) begin nCompared++; if ((act) !== (exp)) begin \
  errCount++; $display("unexpected at %0t: got %h expected %h", \
  $time, (act), (exp)); end end
module tb
  import sev_pkg::*;
;
  logic        clk;        // Bench clock
  logic        reset;      // Synchronous reset
  logic        clkEn;      // Clock enable
  logic [15:0] measCond;   // Measurement conditions by bit
  logic [6:0]  otherCond;  // Junction, cal bad/done, warn, meas, trig, idle
  sev_sel_t    querySel;   // Host read select
  logic        queryStrobe, enableWrite, presetStrobe;
  sev_sel_t    enableSel;  // Host enable select
  logic [15:0] enableData; // Host enable data
  logic        queryValid, measSummary, quesSummary, operSummary;
  logic        calDefaultUsed, faultLamp;
  logic [15:0] queryData;  // Read answer
  int          errCount;   // Mismatches
  int          nCompared;  // Comparisons
  // Clock, 10 ns period
  initial clk = 1'b0;
  always #5 clk = ~clk;
  sev_status_regs DUT (
    .clk(clk), .reset(reset), .clkEn(clkEn),
    .readingOverflow(measCond[0]), .belowLowerLimitOne(measCond[1]),
    .aboveUpperLimitOne(measCond[2]), .belowLowerLimitTwo(measCond[3]),
    .aboveUpperLimitTwo(measCond[4]), .newReadingReady(measCond[5]),
    .bufferHasReadings(measCond[7]), .bufferHalfLevel(measCond[8]),
    .bufferFullFlag(measCond[9]), .junctionInvalid(otherCond[0]),
    .calConstBad(otherCond[1]), .calDone(otherCond[2]),
    .cmdParamIgnored(otherCond[3]), .measuring(otherCond[4]),
    .triggering(otherCond[5]), .idle(otherCond[6]),
    .queryStrobe(queryStrobe), .querySel(querySel),
    .enableWrite(enableWrite), .enableSel(enableSel),
    .enableData(enableData), .presetStrobe(presetStrobe),
    .queryValid(queryValid), .queryData(queryData),
    .measSummary(measSummary), .quesSummary(quesSummary),
    .operSummary(operSummary), .calDefaultUsed(calDefaultUsed),
    .faultLamp(faultLamp));
  sev_host_model host (
    .clk(clk), .querySel(querySel), .queryStrobe(queryStrobe),
    .enableWrite(enableWrite), .enableSel(enableSel),
    .enableData(enableData), .presetStrobe(presetStrobe),
    .queryValid(queryValid), .queryData(queryData));
  // Advance n edges, landing just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Drive conditions for one cycle
  task automatic pulse(input logic [15:0] m, input logic [6:0] o);
    measCond  = m;
    otherCond = o;
    step(1);
    measCond  = 16'h0000;
    otherCond = 7'h00;
  endtask
  // Read a register and compare with the expected word
  task automatic rd(input logic [2:0] sel, input logic [15:0] exp);
    logic [15:0] d;
    logic        seen;
    host.query(sel, d, seen);
    `CHK(seen, 1'b1)
    `CHK(d, exp)
  endtask
  // Each measurement bit alone, then cleared by the read
  task automatic meas_bit(input int b);
    pulse(16'h0001 << b, 7'h00);
    rd(SEV_SEL_MEAS, 16'h0001 << b);
    rd(SEV_SEL_MEAS, 16'h0000);
  endtask
  task automatic t_meas();
    meas_bit(0);
    meas_bit(1);
    meas_bit(2);
    meas_bit(3);
    meas_bit(4);
    meas_bit(5);
    meas_bit(7);
    meas_bit(8);
    meas_bit(9);
    pulse(16'hffff, 7'h00);
    rd(SEV_SEL_MEAS, 16'h03bf);
    // Frozen clock enable must not capture anything
    clkEn = 1'b0;
    pulse(16'h0001, 7'h00);
    clkEn = 1'b1;
    rd(SEV_SEL_MEAS, 16'h0000);
    // Condition held through the read survives the clear
    measCond = 16'h0020;
    step(1);
    rd(SEV_SEL_MEAS, 16'h0020);
    measCond = 16'h0000;
    rd(SEV_SEL_MEAS, 16'h0020);
    rd(SEV_SEL_MEAS, 16'h0000);
    $display("test meas done");
  endtask
  task automatic t_ques_oper();
    logic [15:0] d;
    logic        seen;
    pulse(16'h0000, 7'h01);
    step(1);
    `CHK(faultLamp, 1'b1)
    rd(SEV_SEL_QUES, 16'h0010);
    `CHK(faultLamp, 1'b0)
    pulse(16'h0000, 7'h08);
    rd(SEV_SEL_QUES, 16'h4000);
    pulse(16'h0000, 7'h10);
    rd(SEV_SEL_OPER, 16'h0010);
    pulse(16'h0000, 7'h20);
    rd(SEV_SEL_OPER, 16'h0020);
    pulse(16'h0000, 7'h40);
    rd(SEV_SEL_OPER, 16'h0400);
    // Bad select answers zero and leaves the event in place
    pulse(16'h0001, 7'h00);
    host.query(3'b011, d, seen);
    `CHK(seen, 1'b1)
    `CHK(d, 16'h0000)
    rd(SEV_SEL_MEAS, 16'h0001);
    $display("test ques_oper done");
  endtask
  task automatic t_cal();
    logic [15:0] d;
    logic        seen;
    pulse(16'h0000, 7'h02);
    `CHK(calDefaultUsed, 1'b1)
    step(2);
    `CHK(faultLamp, 1'b1)
    rd(SEV_SEL_QUES, 16'h0100);
    rd(SEV_SEL_QUES, 16'h0100);
    pulse(16'h0000, 7'h04);
    `CHK(calDefaultUsed, 1'b0)
    host.query(SEV_SEL_QUES, d, seen);
    `CHK(d, 16'h0100)
    rd(SEV_SEL_QUES, 16'h0000);
    $display("test cal done");
  endtask
  task automatic t_enable();
    host.write_en(SEV_SEL_MEAS, 16'h0020);
    pulse(16'h0020, 7'h00);
    step(1);
    `CHK(measSummary, 1'b1)
    host.write_en(SEV_SEL_MEAS, 16'h0200);
    `CHK(measSummary, 1'b0)
    host.write_en(SEV_SEL_MEAS, 16'h0020);
    `CHK(measSummary, 1'b1)
    host.preset();
    `CHK(measSummary, 1'b0)
    host.write_en(SEV_SEL_QUES, 16'h0010);
    host.write_en(SEV_SEL_OPER, 16'h0400);
    pulse(16'h0000, 7'h41);
    step(1);
    `CHK(quesSummary, 1'b1)
    `CHK(operSummary, 1'b1)
    rd(SEV_SEL_QUES, 16'h0010);
    step(1);
    `CHK(quesSummary, 1'b0)
    $display("test enable done");
  endtask
  // Print counts and verdict, then stop
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    errCount  = 0;
    nCompared = 0;
    reset     = 1'b1;
    clkEn     = 1'b1;
    measCond  = 16'h0000;
    otherCond = 7'h00;
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    `CHK(queryValid, 1'b0)
    `CHK(faultLamp, 1'b0)
    t_meas();
    t_ques_oper();
    t_cal();
    t_enable();
    tally_and_finish();
  end
  // Watchdog well past the expected 120 or so cycles
  initial begin
    repeat (5000) @(posedge clk);
    errCount++;
    tally_and_finish();
  end
endmodule
